/* File: ilc_codec.sv */
// Inductive link codec: frequency-shift encoder for outgoing bytes and
// differential bi-phase packet decoder for the incoming envelope.
// Assumes power_cycle_tick pulses once per power-signal cycle and that both
// envelope inputs are comparator outputs synchronous to mclk.
// Contract
// R1: Send data by shifting the inverter drive between two frequencies.
// R2: Change frequency only on 256-power-cycle block boundaries.
// R3: Start bit is 512 cycles at the shifted frequency.
// R4: One bit is 256 cycles at one frequency then 256 at the other.
// R5: Zero bit is 512 cycles at one unchanged frequency.
// R6: Byte goes out as start, data, parity, stop.
// R7: Receiver talks by load modulation at 2 kbit per second.
// R8: Incoming bits decode as differential bi-phase at 2 kHz.
// R9: Two short transitions within one bit period decode as one.
// R10: One long transition across the bit period decodes as zero.
// R11: Received byte is start, 8 data, parity, stop: 11 bits.
// R12: Packet is preamble, header, message bytes, checksum.
// R13: Digital decoder turns the conditioned envelope into packets.
// R14: One decoder serves the voltage and current envelope paths.
// R15: Decoder uses whichever path gives the better demodulated signal.
// R16: Silence after configuration means the receiver assumes the baseline profile.
// R17: Drop bad-parity, bad-stop bytes and bad-checksum packets, flag each; bytes of a bad-checksum packet still go out on valid, flagged by chk_err only.
// R18: Encoder counts power cycles, reports completion after last stop bit.
`timescale 1ns/1ps
`default_nettype none
module ilc_codec
   import ilc_pkg::*;
#(
   parameter logic [ASK_CNT_W-1:0] HALF_BIT_CYC = ASK_CNT_W'(ASK_HALF_CYC),
   parameter logic [ASK_CNT_W-1:0] TIMEOUT_CYC = ASK_CNT_W'(ASK_TIMEOUT_HALVES * ASK_HALF_CYC)
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic power_cycle_tick,
   input wire logic tx_valid,
   input wire ilc_tx_req_t tx_req,
   output logic tx_ready,
   output logic tx_done,
   output logic shifted_freq_sel,
   input wire logic voltage_envelope_input,
   input wire logic current_envelope_input,
   output logic current_path_sel,
   output ilc_rx_out_t rx_out
);

   typedef struct packed {
      ilc_tx_st_t tx_st;
      logic [FSK_CNT_W-1:0] pc;
      logic [3:0] bit_i;
      logic [7:0] sh;
      logic par;
      logic last;
      logic freq;
      logic done;
      ilc_rx_st_t rx_st;
      logic prev;
      logic [ASK_CNT_W-1:0] iv;
      logic half_pend;
      logic [3:0] ones;
      logic [3:0] rbit;
      logic [9:0] rsh;
      logic [7:0] chk;
      logic [7:0] nbytes;
      logic path;
      ilc_rx_out_t out;
   } ilc_state_t;

   ilc_state_t st_q;
   ilc_state_t st_d;
   logic [SCORE_W-1:0] volt_score;
   logic [SCORE_W-1:0] curr_score;
   logic env;
   logic env_edge;
   ilc_iv_t iv_cls;
   logic cur_bit;
   logic bit_end;
   logic bit_ev;
   logic bit_val;
   logic sync_err;
   logic timeout;
   logic [9:0] rsh_next;

   // Both paths are scored all the time so the choice is ready at packet start
   ilc_path_quality #(.HALF_BIT_CYC(HALF_BIT_CYC)) u_volt_q (
      .mclk(mclk),
      .reset_n(reset_n),
      .env(voltage_envelope_input),
      .score(volt_score)
   );

   ilc_path_quality #(.HALF_BIT_CYC(HALF_BIT_CYC)) u_curr_q (
      .mclk(mclk),
      .reset_n(reset_n),
      .env(current_envelope_input),
      .score(curr_score)
   );

   // Ready only on a power-cycle tick so every shift lands on a cycle boundary
   assign tx_ready = power_cycle_tick &&
      (st_q.tx_st == TX_IDLE || (st_q.tx_st == TX_STOP && st_q.pc == FSK_BIT_LAST));
   assign bit_end = power_cycle_tick && st_q.pc == FSK_BIT_LAST;

   always_comb begin
      unique case (st_q.tx_st)
         TX_DATA: cur_bit = st_q.sh[0];
         TX_PARITY: cur_bit = st_q.par;
         TX_STOP: cur_bit = 1'b1;
         default: cur_bit = 1'b0;
      endcase
   end

   assign env = st_q.path ? current_envelope_input : voltage_envelope_input; // [R14]
   assign env_edge = env != st_q.prev;
   assign iv_cls = ilc_classify(st_q.iv, HALF_BIT_CYC);
   assign timeout = !env_edge && st_q.iv == TIMEOUT_CYC - 1'b1;

   // Bi-phase bit recovery from edge spacing
   always_comb begin
      bit_ev = 1'b0;
      bit_val = 1'b0;
      sync_err = 1'b0;
      if (env_edge) begin
         unique case (iv_cls)
            IV_SHORT: begin
               bit_ev = st_q.half_pend; // [R9]
               bit_val = 1'b1;
            end
            IV_LONG: begin
               // While hunting, the first long gap is the start bit and fixes the pairing phase
               bit_ev = !st_q.half_pend || st_q.rx_st == RX_HUNT; // [R10]
               sync_err = st_q.half_pend && st_q.rx_st != RX_HUNT;
            end
            IV_GLITCH: sync_err = 1'b1;
            IV_STRAY: begin
            end
         endcase
      end
   end

   assign rsh_next = {bit_val, st_q.rsh[9:1]};

   always_comb begin
      st_d = st_q;
      st_d.done = 1'b0;
      st_d.out.valid = 1'b0;
      st_d.out.header = 1'b0;
      st_d.out.pkt_ok = 1'b0;
      st_d.out.chk_err = 1'b0;
      st_d.out.byte_err = 1'b0;

      // Encoder
      if (tx_valid && tx_ready) begin
         st_d.tx_st = TX_START;
         st_d.pc = '0;
         st_d.sh = tx_req.data;
         st_d.par = ilc_odd_parity(tx_req.data);
         st_d.last = tx_req.last;
         st_d.freq = 1'b1; // [R3]
         st_d.done = st_q.tx_st == TX_STOP && st_q.last; // [R18]
      end else if (power_cycle_tick && st_q.tx_st != TX_IDLE) begin
         st_d.pc = st_q.pc + 1'b1; // [R18]
         if (st_q.pc == FSK_MID_LAST && cur_bit) st_d.freq = !st_q.freq; // [R4] [R2]
         if (st_q.pc == FSK_BIT_LAST) begin
            // Every bit boundary before the stop bit flips the drive; a zero then holds all 512 cycles
            st_d.freq = !st_q.freq; // [R1] [R5] [R2]
            unique case (st_q.tx_st)
               TX_START: begin
                  st_d.tx_st = TX_DATA; // [R6]
                  st_d.bit_i = '0;
               end
               TX_DATA: begin
                  st_d.sh = st_q.sh >> 1;
                  st_d.bit_i = st_q.bit_i + 1'b1;
                  if (st_q.bit_i == DATA_LAST_IDX) st_d.tx_st = TX_PARITY; // [R6]
               end
               TX_PARITY: st_d.tx_st = TX_STOP; // [R6]
               TX_STOP: begin
                  st_d.tx_st = TX_IDLE;
                  st_d.freq = 1'b0;
                  st_d.done = st_q.last; // [R18]
               end
               default: st_d.tx_st = TX_IDLE;
            endcase
         end
      end

      // Decoder front end
      st_d.prev = env;
      if (env_edge) st_d.iv = '0;
      else if (st_q.iv != TIMEOUT_CYC) st_d.iv = st_q.iv + 1'b1;
      if (env_edge && iv_cls == IV_SHORT) st_d.half_pend = !st_q.half_pend; // [R8]
      else if (env_edge) st_d.half_pend = 1'b0;

      // Packet framing
      unique case (st_q.rx_st)
         RX_HUNT: begin
            // Switching paths only between packets keeps one packet on one path
            if (curr_score > volt_score) st_d.path = 1'b1; // [R15]
            else if (volt_score > curr_score) st_d.path = 1'b0; // [R15]
            if (sync_err || timeout) begin
               st_d.ones = '0;
            end else if (bit_ev && bit_val) begin
               if (st_q.ones != 4'hf) st_d.ones = st_q.ones + 1'b1; // [R12]
            end else if (bit_ev) begin
               st_d.ones = '0;
               if (st_q.ones >= PREAMBLE_MIN_ONES) begin
                  st_d.rx_st = RX_BYTE; // [R12] [R13]
                  st_d.rbit = 4'h1;
                  st_d.chk = '0;
                  st_d.nbytes = '0;
               end
            end
         end
         RX_BYTE: begin
            if (timeout) begin
               st_d.rx_st = RX_HUNT;
               if (st_q.rbit == '0 && st_q.nbytes >= MIN_PACKET_BYTES) begin
                  st_d.out.pkt_ok = st_q.chk == '0; // [R12]
                  st_d.out.chk_err = st_q.chk != '0; // [R17]
               end else begin
                  st_d.out.byte_err = 1'b1; // [R17]
               end
            end else if (sync_err) begin
               st_d.rx_st = RX_HUNT;
               st_d.out.byte_err = 1'b1; // [R17]
            end else if (bit_ev) begin
               if (st_q.rbit == '0) begin
                  st_d.rbit = 4'h1;
                  if (bit_val) begin
                     st_d.rx_st = RX_HUNT;
                     st_d.out.byte_err = 1'b1; // [R17]
                  end
               end else begin
                  st_d.rsh = rsh_next; // [R11]
                  st_d.rbit = st_q.rbit + 1'b1;
                  if (st_q.rbit == STOP_IDX) begin
                     st_d.rbit = '0;
                     if (rsh_next[9] && rsh_next[8] == ilc_odd_parity(rsh_next[7:0])) begin
                        st_d.out.data = rsh_next[7:0]; // [R11]
                        st_d.out.valid = 1'b1;
                        st_d.out.header = st_q.nbytes == '0; // [R12]
                        st_d.chk = st_q.chk ^ rsh_next[7:0];
                        if (st_q.nbytes != 8'hff) st_d.nbytes = st_q.nbytes + 1'b1;
                     end else begin
                        st_d.rx_st = RX_HUNT;
                        st_d.out.byte_err = 1'b1; // [R17]
                     end
                  end
               end
            end
         end
         default: st_d.rx_st = RX_HUNT;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '0;
         st_q.tx_st <= TX_IDLE;
         st_q.rx_st <= RX_HUNT;
      end else begin
         st_q <= st_d;
      end
   end

   assign tx_done = st_q.done;
   assign shifted_freq_sel = st_q.freq;
   assign current_path_sel = st_q.path;
   assign rx_out = st_q.out;

   sequence mid_of_one_s;
      power_cycle_tick && st_q.tx_st != TX_IDLE && st_q.pc == FSK_MID_LAST && cur_bit;
   endsequence

   sequence mid_of_zero_s;
      power_cycle_tick && st_q.tx_st != TX_IDLE && st_q.pc == FSK_MID_LAST && !cur_bit;
   endsequence

   freq_boundary_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R2]
      ($changed(st_q.freq) && st_q.tx_st != TX_IDLE) |-> (st_q.pc == FSK_MID_FIRST || st_q.pc == '0))
      else $error("frequency changed off a block boundary");

   start_shifted_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R3]
      st_q.tx_st == TX_START |-> st_q.freq) else $error("start bit not at shifted frequency");

   one_splits_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R4]
      mid_of_one_s |=> st_q.freq != $past(st_q.freq)) else $error("one bit did not flip at mid bit");

   zero_holds_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R5]
      mid_of_zero_s |=> $stable(st_q.freq)) else $error("zero bit changed frequency");

   stop_order_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R6]
      (st_q.tx_st == TX_STOP && $past(st_q.tx_st) != TX_STOP) |-> $past(st_q.tx_st) == TX_PARITY)
      else $error("stop bit not preceded by parity");

   done_after_stop_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R18]
      (bit_end && st_q.tx_st == TX_STOP && st_q.last) |=> tx_done) else $error("completion not reported");

   path_hold_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R15]
      (st_q.rx_st == RX_BYTE && $past(st_q.rx_st) == RX_BYTE) |-> $stable(st_q.path))
      else $error("path switched inside a packet");

   byte_excl_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R17]
      rx_out.byte_err |-> !rx_out.valid ##1 st_q.rx_st == RX_HUNT) else $error("bad byte delivered");

   byte_frame_a: assert property (@(posedge mclk) disable iff (!reset_n) // [R11]
      rx_out.valid |-> $past(st_q.rbit) == STOP_IDX && $past(st_q.rx_st) == RX_BYTE)
      else $error("byte delivered off the stop bit");

endmodule
`default_nettype wire

/* File: ilc_pkg.sv */
// Package for the inductive link codec: timing counts, state encodings,
// carrier structs and shared decode functions.
// Assumes a 20 MHz mclk and a one-cycle power-cycle tick from the bridge timer.
package ilc_pkg;

   // System clock and receive bit clock
   localparam int MCLK_HZ = 20_000_000;
   localparam int ASK_BIT_RATE_HZ = 2000;
   localparam int ASK_HALF_CYC = MCLK_HZ / (2 * ASK_BIT_RATE_HZ);
   localparam int ASK_CNT_W = 16;
   localparam int ASK_TIMEOUT_HALVES = 3;

   // Transmit timing, counted in power-signal cycles
   localparam int FSK_HALF_CYCLES = 256;
   localparam int FSK_BIT_CYCLES = 512;
   localparam int FSK_CNT_W = 9;
   localparam logic [FSK_CNT_W-1:0] FSK_MID_LAST = 9'h0ff;
   localparam logic [FSK_CNT_W-1:0] FSK_BIT_LAST = 9'h1ff;
   localparam logic [FSK_CNT_W-1:0] FSK_MID_FIRST = 9'h100;

   // Byte framing
   localparam int DATA_BITS = 8;
   localparam logic [3:0] DATA_LAST_IDX = 4'h7;
   localparam logic [3:0] STOP_IDX = 4'ha;
   localparam logic [3:0] PREAMBLE_MIN_ONES = 4'h4;
   localparam logic [7:0] MIN_PACKET_BYTES = 8'h02;

   // Path quality score
   localparam int SCORE_W = 6;
   localparam logic [SCORE_W-1:0] SCORE_MAX = 6'h3f;
   localparam logic [SCORE_W-1:0] SCORE_PENALTY = 6'h02;

   typedef enum logic [3:0] {
      IV_GLITCH = 4'h1,
      IV_SHORT = 4'h2,
      IV_LONG = 4'h4,
      IV_STRAY = 4'h8
   } ilc_iv_t;

   typedef enum logic [4:0] {
      TX_IDLE = 5'h01,
      TX_START = 5'h02,
      TX_DATA = 5'h04,
      TX_PARITY = 5'h08,
      TX_STOP = 5'h10
   } ilc_tx_st_t;

   typedef enum logic [1:0] {
      RX_HUNT = 2'h1,
      RX_BYTE = 2'h2
   } ilc_rx_st_t;

   typedef struct packed {
      logic [7:0] data;
      logic valid;
      logic header;
      logic pkt_ok;
      logic chk_err;
      logic byte_err;
   } ilc_rx_out_t;

   typedef struct packed {
      logic [7:0] data;
      logic last;
   } ilc_tx_req_t;

   // Sorts an edge-to-edge interval against the half-bit time
   function automatic ilc_iv_t ilc_classify(input logic [ASK_CNT_W-1:0] iv, input logic [ASK_CNT_W-1:0] half);
      logic [ASK_CNT_W+1:0] h;
      logic [ASK_CNT_W+1:0] v;
      h = {2'b00, half};
      v = {2'b00, iv};
      if (v < (h >> 1)) return IV_GLITCH;
      else if (v < h + (h >> 1)) return IV_SHORT;
      else if (v < (h << 1) + (h >> 1)) return IV_LONG;
      else return IV_STRAY;
   endfunction

   function automatic logic ilc_odd_parity(input logic [7:0] b);
      return ~(^b);
   endfunction

endpackage

/* File: ilc_path_quality.sv */
// Quality monitor for one envelope path: scores how often the edge spacing
// matches the receive bit clock.
// Assumes the envelope comparator output is synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module ilc_path_quality
   import ilc_pkg::*;
#(
   parameter logic [ASK_CNT_W-1:0] HALF_BIT_CYC = ASK_CNT_W'(ASK_HALF_CYC)
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic env,
   output logic [SCORE_W-1:0] score
);

   typedef struct packed {
      logic prev;
      logic [ASK_CNT_W-1:0] iv;
      logic [SCORE_W-1:0] score;
   } ilc_pq_state_t;

   ilc_pq_state_t st_q;
   ilc_pq_state_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.prev = env;
      if (env != st_q.prev) begin
         st_d.iv = '0;
         unique case (ilc_classify(st_q.iv, HALF_BIT_CYC))
            IV_SHORT, IV_LONG: begin
               if (st_q.score != SCORE_MAX) st_d.score = st_q.score + 1'b1;
            end
            IV_GLITCH: begin
               // Noise edges cost more than a good edge earns
               st_d.score = (st_q.score > SCORE_PENALTY) ? st_q.score - SCORE_PENALTY : '0;
            end
            IV_STRAY: begin
            end
         endcase
      end else if (st_q.iv != '1) begin
         st_d.iv = st_q.iv + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) st_q <= '0;
      else st_q <= st_d;
   end

   assign score = st_q.score;

   score_bound_a: assert property (@(posedge mclk) disable iff (!reset_n)
      (env == st_q.prev) |=> $stable(st_q.score)) else $error("score moved without an edge"); // [R15]

endmodule
`default_nettype wire

/* File: ilc_rx_partner.sv */
// Receiver model: load-modulates packets onto both envelope paths as
// differential bi-phase levels, with optional glitches on the voltage path.
// Assumes its tasks are called from a process sitting just after a mclk edge.
`timescale 1ns/1ps
`default_nettype none
module ilc_rx_partner #(
   parameter int HALF = 20
) (
   input wire logic mclk,
   input wire logic shift_drive,
   output logic v_env,
   output logic i_env
);
   logic lvl = 1'b0;
   logic noisy = 1'b0;
   logic glitch = 1'b0;
   logic baseline_profile = 1'b0;

   assign v_env = lvl ^ glitch;
   assign i_env = lvl;

   // Glitch is two cycles wide, well under half a half-bit, so it only spoils spacing
   task automatic half_bit(input logic flip);
      if (flip) lvl <= ~lvl;
      repeat (HALF / 2) @(posedge mclk);
      if (noisy) glitch <= 1'b1;
      repeat (2) @(posedge mclk);
      glitch <= 1'b0;
      repeat (HALF / 2 - 2) @(posedge mclk);
   endtask

   // Bit time is two half-bits, the scaled 2 kbit/s rate
   task automatic send_bit(input logic b);
      half_bit(1'b1);
      half_bit(b);
   endtask

   task automatic send_packet(input logic [3:0][7:0] b, input int n, input int bad, input logic nz);
      logic [10:0] f;
      @(posedge mclk);
      noisy <= nz;
      for (int i = 0; i < 11; i++) send_bit(1'b1);
      for (int j = 0; j < n; j++) begin
         f = {1'b1, ~(^b[j]) ^ (j == bad), b[j], 1'b0};
         for (int i = 0; i < 11; i++) send_bit(f[i]);
      end
      noisy <= 1'b0;
      // A closing edge ends the last stop bit so its second half can be paired
      half_bit(1'b1);
   endtask

   // A packet left unanswered by any frequency shift leaves the receiver on the baseline profile
   task automatic await_reply(input int span);
      logic seen;
      seen = 1'b0;
      repeat (span) begin
         @(negedge mclk);
         if (shift_drive !== 1'b0) seen = 1'b1;
      end
      baseline_profile = !seen;
   endtask
endmodule
`default_nettype wire

/* File: ilc_codec_tb_top.sv */
// Self-checking bench for the inductive link codec.
// Assumes a power cycle every second mclk and shortened receive timing.
`timescale 1ns/1ps
`default_nettype none
module ilc_codec_tb_top;
   import ilc_pkg::*;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic tick = 1'b0;
   logic tx_valid = 1'b0;
   ilc_tx_req_t tx_req = '0;
   logic tx_ready, tx_done, freq, v_env, i_env, path_sel;
   ilc_rx_out_t rx_out;
   int err_count = 0;
   int total_checks = 0;
   int done_cnt = 0;
   int ok_cnt = 0;
   int chk_cnt = 0;
   int berr_cnt = 0;
   logic [7:0] got_q[$];
   logic hdr_q[$];
   logic s [0:5632];

`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
   $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end

   always #25 mclk = ~mclk;
   always @(posedge mclk) tick <= ~tick;

   ilc_codec #(.HALF_BIT_CYC(16'h0014), .TIMEOUT_CYC(16'h003c)) uut (.mclk(mclk), .reset_n(reset_n),
      .power_cycle_tick(tick), .tx_valid(tx_valid), .tx_req(tx_req), .tx_ready(tx_ready), .tx_done(tx_done),
      .shifted_freq_sel(freq), .voltage_envelope_input(v_env), .current_envelope_input(i_env),
      .current_path_sel(path_sel), .rx_out(rx_out));
   ilc_rx_partner #(.HALF(20)) u_rx (.mclk(mclk), .shift_drive(freq), .v_env(v_env), .i_env(i_env));

   // Sampled mid-cycle so one-cycle pulses are seen once and settled
   always @(negedge mclk) begin
      if (tx_done === 1'b1) done_cnt++;
      if (rx_out.pkt_ok === 1'b1) ok_cnt++;
      if (rx_out.chk_err === 1'b1) chk_cnt++;
      if (rx_out.byte_err === 1'b1) berr_cnt++;
      if (rx_out.valid === 1'b1) begin
         got_q.push_back(rx_out.data);
         hdr_q.push_back(rx_out.header);
      end
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Records the drive level at every power cycle of one byte, then decodes it
   task automatic tx_byte(input logic [7:0] d, input logic last);
      int viol;
      int d0;
      logic [10:0] f;
      viol = 0;
      d0 = done_cnt;
      f = {1'b1, ~(^d), d, 1'b0};
      @(posedge mclk);
      tx_req <= '{data: d, last: last};
      tx_valid <= 1'b1;
      do @(negedge mclk); while (tx_ready !== 1'b1);
      @(posedge mclk);
      tx_valid <= 1'b0;
      for (int k = 1; k <= 5632; k++) begin
         do @(negedge mclk); while (tick !== 1'b1);
         s[k] = freq;
         if (k > 1 && s[k] !== s[k-1] && (k - 1) % 256 != 0) viol++;
      end
      `CHK("freq block", 0, viol)
      `CHK("start level", 1'b1, s[129])
      for (int i = 0; i < 11; i++) `CHK("tx bit", f[i], s[512*i+129] ^ s[512*i+385])
      repeat (3) @(posedge mclk);
      `CHK("tx done", int'(last), done_cnt - d0)
      if (last) `CHK("idle freq", 1'b0, freq)
   endtask

   task automatic rx_pkt(input logic [3:0][7:0] b, input int n, input int bad, input logic nz,
                         input int xok, input int xchk);
      int o0;
      int c0;
      int e0;
      int m;
      got_q.delete();
      hdr_q.delete();
      o0 = ok_cnt;
      c0 = chk_cnt;
      e0 = berr_cnt;
      m = (bad >= 0) ? n - 1 : n;
      u_rx.send_packet(b, n, bad, nz);
      u_rx.await_reply(200);
      `CHK("baseline", 1'b1, u_rx.baseline_profile)
      `CHK("rx bytes", m, got_q.size())
      for (int i = 0; i < m && i < got_q.size(); i++) `CHK("rx data", b[i], got_q[i])
      if (hdr_q.size() > 0) `CHK("rx header", 1'b1, hdr_q[0])
      `CHK("pkt ok", xok, ok_cnt - o0)
      if (xchk >= 0) `CHK("chk err", xchk, chk_cnt - c0)
      `CHK("byte err", bad >= 0, berr_cnt > e0)
      `CHK("path sel", nz, path_sel)
   endtask

   task automatic sc_tx_pair;
      tx_byte(8'ha5, 1'b0);
      tx_byte(8'h3c, 1'b1);
   endtask

   task automatic sc_rx_clean;
      rx_pkt({8'h00, 8'h87, 8'h81, 8'h06}, 3, -1, 1'b0, 1, 0);
   endtask

   task automatic sc_rx_bad_sum;
      rx_pkt({8'h00, 8'h12, 8'h34, 8'h20}, 3, -1, 1'b0, 0, 1);
   endtask

   // Parity fault on the checksum byte: earlier bytes stay delivered
   task automatic sc_rx_bad_parity;
      rx_pkt({8'h00, 8'h55, 8'h11, 8'h44}, 3, 2, 1'b0, 0, -1);
   endtask

   task automatic sc_rx_noisy;
      rx_pkt({8'h00, 8'h45, 8'h5a, 8'h1f}, 3, -1, 1'b1, 1, 0);
   endtask

   initial begin
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      sc_tx_pair();
      sc_rx_clean();
      sc_rx_bad_sum();
      sc_rx_bad_parity();
      sc_rx_noisy();
      end_sim();
   end

   initial begin
      repeat (80000) @(posedge mclk);
      err_count++;
      end_sim();
   end
endmodule
`default_nettype wire
